// ===== bxl_exec.v
/*
 * Execute block for the memory barriers, the register exclusive-OR, the
 * load-multiple and the immediate, stack-relative and literal word loads.
 * Assumes a register file that answers the read indices in the same cycle,
 * a memory port with a request held until a one-cycle acknowledge, and a
 * fetch unit that honours the flush pulse and refetch address.
 */
`timescale 1ns/10ps
`include "bxl_defines.vh"

// Behaviour
// - Ordering barrier option 1111 is full-system form
// - Other ordering options still run as full-system
// - Completion barrier stalls until accesses, maintenance finish
// - Completion barrier: every option runs full-system
// - Fetch barrier flushes pipeline, later instructions refetched
// - Completed context changes visible after fetch barrier
// - Later branches predicted with post-barrier context
// - Fetch barrier: reserved options run full-system
// - XOR first and second register, no shift
// - Flags set outside IT: N, Z, shifter C
// - Load list ascending from base, step four
// - Writeback base plus four times count
// - Register load offset is imm5 times four
// - Stack load uses register 13, imm8 times four
// - Offset addressing, one word, no base writeback
// - Literal load adds imm8 times four
// - Literal base is program counter rounded down
// - Ordering barrier orders memory accesses only
module bxl_exec
(
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire        instr_valid,
   input  wire [31:0] instr,
   input  wire        instr_is_32,
   input  wire [31:0] instr_pc,
   input  wire        cond_pass,
   input  wire        in_it_block,
   input  wire        flag_c_in,
   input  wire [31:0] rd_a_data,
   input  wire [31:0] rd_b_data,
   input  wire        mem_ack,
   input  wire [31:0] mem_rdata,
   input  wire        mem_idle,
   input  wire        maint_idle,
   output reg         instr_ready_reg,
   output reg         done_reg,
   output reg         undef_reg,
   output reg  [3:0]  rd_a_idx_reg,
   output reg  [3:0]  rd_b_idx_reg,
   output reg         wb_en_reg,
   output reg  [3:0]  wb_idx_reg,
   output reg  [31:0] wb_data_reg,
   output reg         flag_wr_reg,
   output reg         flag_n_reg,
   output reg         flag_z_reg,
   output reg         flag_c_reg,
   output reg         mem_req_reg,
   output reg  [31:0] mem_addr_reg,
   output reg         mem_aligned_reg,
   output reg         order_fence_reg,
   output reg         full_scope_reg,
   output reg         flush_reg,
   output reg         bp_ctx_sync_reg,
   output reg  [31:0] refetch_addr_reg
);

   // ============================================================
   // State encoding
   // ============================================================
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_OPER = 7'h02;
   localparam [6:0] S_MEM  = 7'h04;
   localparam [6:0] S_STEP = 7'h08;
   localparam [6:0] S_WBB  = 7'h10;
   localparam [6:0] S_BAR  = 7'h20;
   localparam [6:0] S_FIN  = 7'h40;

   reg  [1:0]  rst_sync_reg;
   wire        rst_n;

   reg  [6:0]  state_reg;
   reg  [2:0]  cls_reg;
   reg  [3:0]  bar_kind_reg;
   reg  [3:0]  bar_opt_reg;
   reg  [3:0]  tgt_reg;
   reg  [3:0]  base_idx_reg;
   reg  [31:0] base_val_reg;
   reg  [31:0] offset_reg;
   reg  [31:0] pc_reg;
   reg  [7:0]  list_reg;
   reg  [3:0]  cnt_reg;
   reg         wback_reg;
   reg         setflags_reg;

   wire [2:0]  dec_cls;
   wire [3:0]  dec_bar_kind;
   wire [3:0]  dec_bar_opt;
   wire [3:0]  dec_idx_a;
   wire [3:0]  dec_idx_b;
   wire [3:0]  dec_idx_t;
   wire [31:0] dec_offset;
   wire [3:0]  dec_list_cnt;
   wire [2:0]  dec_first_idx;

   wire [31:0] xor_result;
   wire [7:0]  tgt_onehot;
   wire [7:0]  list_after;
   wire [31:0] lit_base;
   wire [31:0] wb_base_val;
   wire        bar_full;
   wire        complete_ready;

   // ============================================================
   // Reset release
   // ============================================================
   // Assertion is immediate; release is synchronised so no flop sees a runt edge
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         rst_sync_reg <= 2'b00;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end

   assign rst_n = rst_sync_reg[1];

   // ============================================================
   // Decoder
   // ============================================================
   bxl_decode u_decode
   (
      .instr     (instr),
      .is_32     (instr_is_32),
      .list_rem  (list_reg),
      .cls       (dec_cls),
      .bar_kind  (dec_bar_kind),
      .bar_opt   (dec_bar_opt),
      .idx_a     (dec_idx_a),
      .idx_b     (dec_idx_b),
      .idx_t     (dec_idx_t),
      .offset    (dec_offset),
      .list_cnt  (dec_list_cnt),
      .first_idx (dec_first_idx)
   );

   // ============================================================
   // Datapath terms
   // ============================================================
   // Second operand passes the shifter with a zero shift, so it is unchanged
   assign xor_result  = rd_a_data ^ rd_b_data;
   assign tgt_onehot  = 8'h01 << tgt_reg[2:0];
   assign list_after  = list_reg & ~tgt_onehot;
   assign lit_base    = pc_reg & `BXL_WORD_MASK;
   assign wb_base_val = base_val_reg + {26'h0, cnt_reg, 2'b00};

   // Option field is kept for visibility only; every value acts as full-system
   assign bar_full = (bar_opt_reg == `BXL_OPT_FULL) || 1'b1;

   // Completion and fetch barriers both need earlier accesses and maintenance done
   assign complete_ready = mem_idle && maint_idle;

   // ============================================================
   // Control sequence and outputs
   // ============================================================
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg        <= S_IDLE;
         cls_reg          <= `BXL_CL_NONE;
         bar_kind_reg     <= 4'h0;
         bar_opt_reg      <= 4'h0;
         tgt_reg          <= 4'h0;
         base_idx_reg     <= 4'h0;
         base_val_reg     <= 32'h0000_0000;
         offset_reg       <= 32'h0000_0000;
         pc_reg           <= 32'h0000_0000;
         list_reg         <= 8'h00;
         cnt_reg          <= 4'h0;
         wback_reg        <= 1'b0;
         setflags_reg     <= 1'b0;
         instr_ready_reg  <= 1'b0;
         done_reg         <= 1'b0;
         undef_reg        <= 1'b0;
         rd_a_idx_reg     <= 4'h0;
         rd_b_idx_reg     <= 4'h0;
         wb_en_reg        <= 1'b0;
         wb_idx_reg       <= 4'h0;
         wb_data_reg      <= 32'h0000_0000;
         flag_wr_reg      <= 1'b0;
         flag_n_reg       <= 1'b0;
         flag_z_reg       <= 1'b0;
         flag_c_reg       <= 1'b0;
         mem_req_reg      <= 1'b0;
         mem_addr_reg     <= 32'h0000_0000;
         mem_aligned_reg  <= 1'b0;
         order_fence_reg  <= 1'b0;
         full_scope_reg   <= 1'b0;
         flush_reg        <= 1'b0;
         bp_ctx_sync_reg  <= 1'b0;
         refetch_addr_reg <= 32'h0000_0000;
      end
      else
      begin
         // One-cycle pulses fall back every cycle unless a state raises them
         done_reg        <= 1'b0;
         undef_reg       <= 1'b0;
         wb_en_reg       <= 1'b0;
         flag_wr_reg     <= 1'b0;
         order_fence_reg <= 1'b0;
         flush_reg       <= 1'b0;
         bp_ctx_sync_reg <= 1'b0;
         case (state_reg)
            S_IDLE:
            begin
               instr_ready_reg <= 1'b1;
               if (instr_valid && instr_ready_reg)
               begin
                  instr_ready_reg <= 1'b0;
                  cls_reg         <= dec_cls;
                  bar_kind_reg    <= dec_bar_kind;
                  bar_opt_reg     <= dec_bar_opt;
                  tgt_reg         <= dec_idx_t;
                  base_idx_reg    <= dec_idx_a;
                  offset_reg      <= dec_offset;
                  pc_reg          <= instr_pc;
                  list_reg        <= instr[7:0];
                  cnt_reg         <= dec_list_cnt;
                  // Base writes back only when it is absent from the list
                  wback_reg       <= ~instr[dec_idx_a[2:0]];
                  setflags_reg    <= ~in_it_block;
                  rd_a_idx_reg    <= dec_idx_a;
                  rd_b_idx_reg    <= dec_idx_b;
                  if (!cond_pass || dec_cls == `BXL_CL_NONE)
                  begin
                     undef_reg <= cond_pass;
                     state_reg <= S_FIN;
                  end
                  else
                     state_reg <= S_OPER;
               end
            end
            S_OPER:
            begin
               case (cls_reg)
                  `BXL_CL_XOR:
                  begin
                     wb_en_reg   <= 1'b1;
                     wb_idx_reg  <= tgt_reg;
                     wb_data_reg <= xor_result;
                     if (setflags_reg)
                     begin
                        // Overflow is not driven, so it stays as it was
                        flag_wr_reg <= 1'b1;
                        flag_n_reg  <= xor_result[31];
                        flag_z_reg  <= (xor_result == 32'h0000_0000);
                        flag_c_reg  <= flag_c_in;
                     end
                     state_reg <= S_FIN;
                  end
                  `BXL_CL_LDRI, `BXL_CL_LDRS:
                  begin
                     mem_addr_reg    <= rd_a_data + offset_reg;
                     mem_aligned_reg <= 1'b0;
                     mem_req_reg     <= 1'b1;
                     state_reg       <= S_MEM;
                  end
                  `BXL_CL_LDRL:
                  begin
                     mem_addr_reg    <= lit_base + offset_reg;
                     mem_aligned_reg <= 1'b0;
                     mem_req_reg     <= 1'b1;
                     state_reg       <= S_MEM;
                  end
                  `BXL_CL_LDM:
                  begin
                     base_val_reg <= rd_a_data;
                     // An empty list cannot be encoded usefully; it just retires
                     if (list_reg == 8'h00)
                        state_reg <= S_FIN;
                     else
                     begin
                        tgt_reg         <= {1'b0, dec_first_idx};
                        mem_addr_reg    <= rd_a_data;
                        mem_aligned_reg <= 1'b1;
                        mem_req_reg     <= 1'b1;
                        state_reg       <= S_MEM;
                     end
                  end
                  `BXL_CL_BAR:
                  begin
                     full_scope_reg <= bar_full;
                     if (bar_kind_reg == `BXL_BAR_ORDER)
                     begin
                        // Only memory ordering is asked for; other work is not held
                        order_fence_reg <= 1'b1;
                        state_reg       <= S_FIN;
                     end
                     else
                        state_reg <= S_BAR;
                  end
                  default:
                     state_reg <= S_FIN;
               endcase
            end
            S_MEM:
            begin
               if (mem_ack)
               begin
                  mem_req_reg <= 1'b0;
                  wb_en_reg   <= 1'b1;
                  wb_idx_reg  <= tgt_reg;
                  wb_data_reg <= mem_rdata;
                  if (cls_reg == `BXL_CL_LDM && list_after != 8'h00)
                  begin
                     list_reg  <= list_after;
                     state_reg <= S_STEP;
                  end
                  else if (cls_reg == `BXL_CL_LDM && wback_reg)
                     state_reg <= S_WBB;
                  else
                     state_reg <= S_FIN;
               end
            end
            S_STEP:
            begin
               // Next register comes from the next word up
               tgt_reg      <= {1'b0, dec_first_idx};
               mem_addr_reg <= mem_addr_reg + `BXL_WORD_STEP;
               mem_req_reg  <= 1'b1;
               state_reg    <= S_MEM;
            end
            S_WBB:
            begin
               wb_en_reg   <= 1'b1;
               wb_idx_reg  <= base_idx_reg;
               wb_data_reg <= wb_base_val;
               state_reg   <= S_FIN;
            end
            S_BAR:
            begin
               // Later instructions stay blocked because ready is low here
               if (complete_ready)
               begin
                  if (bar_kind_reg == `BXL_BAR_FETCH)
                  begin
                     flush_reg        <= 1'b1;
                     bp_ctx_sync_reg  <= 1'b1;
                     refetch_addr_reg <= pc_reg;
                  end
                  state_reg <= S_FIN;
               end
            end
            S_FIN:
            begin
               done_reg        <= 1'b1;
               full_scope_reg  <= 1'b0;
               instr_ready_reg <= 1'b1;
               state_reg       <= S_IDLE;
            end
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end

endmodule

// ===== bxl_defines.vh
/*
 * Constants for the barrier, exclusive-OR and word-load execute block:
 * opcode patterns, field codes, register indices and address steps.
 * Assumes the includer already has sys_clk-based logic; holds only defines.
 */
`ifndef BXL_DEFINES_VH
`define BXL_DEFINES_VH

// ============================================================
// Instruction patterns
// ============================================================
`define BXL_BAR_HW1        16'hF3BF
`define BXL_BAR_HW2_TOP    2'h2
`define BXL_BAR_ORDER      4'h5
`define BXL_BAR_COMPLETE   4'h4
`define BXL_BAR_FETCH      4'h6
`define BXL_OPT_FULL       4'hF
`define BXL_XOR_PAT        10'h101
`define BXL_LDM_PAT        5'h19
`define BXL_LDRI_PAT       5'h0D
`define BXL_LDRS_PAT       5'h13
`define BXL_LDRL_PAT       5'h09

// ============================================================
// Decoded instruction classes
// ============================================================
`define BXL_CL_NONE        3'h0
`define BXL_CL_XOR         3'h1
`define BXL_CL_LDRI        3'h2
`define BXL_CL_LDRS        3'h3
`define BXL_CL_LDRL        3'h4
`define BXL_CL_LDM         3'h5
`define BXL_CL_BAR         3'h6

// ============================================================
// Register indices and address arithmetic
// ============================================================
`define BXL_SP_IDX         4'hD
`define BXL_WORD_STEP      32'h0000_0004
`define BXL_WORD_MASK      32'hFFFF_FFFC

`endif

// ===== bxl_decode.v
/*
 * Combinational decoder for the execute block: classifies one 16-bit or
 * 32-bit instruction, extracts register fields and scaled offsets, and
 * scans a load list for its lowest set bit.
 * Assumes a 32-bit instruction sits with its first halfword in bits 31:16.
 */
`timescale 1ns/10ps
`include "bxl_defines.vh"

module bxl_decode
(
   input  wire [31:0] instr,
   input  wire        is_32,
   input  wire [7:0]  list_rem,
   output reg  [2:0]  cls,
   output reg  [3:0]  bar_kind,
   output reg  [3:0]  bar_opt,
   output reg  [3:0]  idx_a,
   output reg  [3:0]  idx_b,
   output reg  [3:0]  idx_t,
   output reg  [31:0] offset,
   output reg  [3:0]  list_cnt,
   output reg  [2:0]  first_idx
);

   wire [15:0] hw;
   wire [15:0] hw2;
   integer     i;

   assign hw  = instr[15:0];
   assign hw2 = instr[15:0];

   // ============================================================
   // Classification and field extraction
   // ============================================================
   // Barriers match on the fixed bits only; should-be-one bits are ignored
   always @*
   begin
      cls      = `BXL_CL_NONE;
      bar_kind = hw2[7:4];
      bar_opt  = hw2[3:0];
      idx_a    = {1'b0, hw[2:0]};
      idx_b    = {1'b0, hw[5:3]};
      idx_t    = {1'b0, hw[2:0]};
      offset   = 32'h0000_0000;
      if (is_32)
      begin
         if (instr[31:16] == `BXL_BAR_HW1 && hw2[15:14] == `BXL_BAR_HW2_TOP &&
             hw2[12] == 1'b0 &&
             (hw2[7:4] == `BXL_BAR_ORDER || hw2[7:4] == `BXL_BAR_COMPLETE ||
              hw2[7:4] == `BXL_BAR_FETCH))
            cls = `BXL_CL_BAR;
      end
      else if (hw[15:6] == `BXL_XOR_PAT)
      begin
         cls   = `BXL_CL_XOR;
         idx_a = {1'b0, hw[2:0]};
         idx_b = {1'b0, hw[5:3]};
         idx_t = {1'b0, hw[2:0]};
      end
      else if (hw[15:11] == `BXL_LDRI_PAT)
      begin
         cls    = `BXL_CL_LDRI;
         idx_a  = {1'b0, hw[5:3]};
         offset = {25'h0, hw[10:6], 2'b00};
      end
      else if (hw[15:11] == `BXL_LDRS_PAT)
      begin
         cls    = `BXL_CL_LDRS;
         idx_a  = `BXL_SP_IDX;
         idx_t  = {1'b0, hw[10:8]};
         offset = {22'h0, hw[7:0], 2'b00};
      end
      else if (hw[15:11] == `BXL_LDRL_PAT)
      begin
         cls    = `BXL_CL_LDRL;
         idx_t  = {1'b0, hw[10:8]};
         offset = {22'h0, hw[7:0], 2'b00};
      end
      else if (hw[15:11] == `BXL_LDM_PAT)
      begin
         cls   = `BXL_CL_LDM;
         idx_a = {1'b0, hw[10:8]};
      end
   end

   // ============================================================
   // Load list: population count and lowest remaining register
   // ============================================================
   always @*
   begin
      list_cnt  = 4'h0;
      first_idx = 3'h0;
      for (i = 0; i < 8; i = i + 1)
         list_cnt = list_cnt + {3'h0, hw[i]};
      // Scan downward so the lowest set bit is the one left standing
      for (i = 7; i >= 0; i = i - 1)
         if (list_rem[i])
            first_idx = i[2:0];
   end

endmodule

// ===== bxl_exec_props.sv
/* Concurrent checks on the ports of bxl_exec.
   Assumes bind onto bxl_exec, one clock, reset_n active low. */
`timescale 1ns/10ps
module bxl_exec_props
(
   input wire        sys_clk,
   input wire        reset_n,
   input wire        mem_ack,
   input wire [31:0] mem_rdata,
   input wire        mem_idle,
   input wire        maint_idle,
   input wire        done_reg,
   input wire        wb_en_reg,
   input wire [31:0] wb_data_reg,
   input wire        flag_wr_reg,
   input wire        flag_n_reg,
   input wire        flag_z_reg,
   input wire        mem_req_reg,
   input wire [31:0] mem_addr_reg,
   input wire        mem_aligned_reg,
   input wire        order_fence_reg,
   input wire        full_scope_reg,
   input wire        flush_reg,
   input wire        bp_ctx_sync_reg
);
   reg [31:0] last_addr_reg;
   reg        ldm_mid_reg;
   // ============================================================
   // Helper: last acknowledged word of a load list
   // ============================================================
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         last_addr_reg <= 32'h0000_0000;
         ldm_mid_reg   <= 1'b0;
      end
      else if (done_reg)
         ldm_mid_reg <= 1'b0;
      else if (mem_req_reg && mem_ack && mem_aligned_reg)
      begin
         last_addr_reg <= mem_addr_reg;
         ldm_mid_reg   <= 1'b1;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Read answered, then written back with the returned word
   sequence word_ack;
      mem_req_reg && mem_ack;
   endsequence
   sequence word_back;
      wb_en_reg && !mem_req_reg;
   endsequence
   ack_wb_a: assert property (word_ack |=> word_back ##0 wb_data_reg == $past(mem_rdata))
      else $error("load data not written back");
   req_hold_a: assert property (mem_req_reg && !mem_ack |=> mem_req_reg && $stable(mem_addr_reg))
      else $error("read request dropped early");
   ldm_step_a: assert property ($rose(mem_req_reg) && mem_aligned_reg && ldm_mid_reg |->
      mem_addr_reg == last_addr_reg + 32'h0000_0004) else $error("list address step wrong");
   fence_only_a: assert property (order_fence_reg |-> !mem_req_reg && !wb_en_reg)
      else $error("ordering barrier touched memory");
   scope_full_a: assert property (order_fence_reg || flush_reg |-> full_scope_reg)
      else $error("barrier not full scope");
   flush_bp_a: assert property (flush_reg |-> bp_ctx_sync_reg)
      else $error("predictor context not synced");
   flush_done_a: assert property (flush_reg |=> done_reg && !flush_reg)
      else $error("flush not followed by retire");
   flush_idle_a: assert property (flush_reg |-> $past(mem_idle) && $past(maint_idle))
      else $error("flush before accesses complete");
   flag_nz_a: assert property (flag_wr_reg |-> flag_n_reg == wb_data_reg[31] &&
      flag_z_reg == (wb_data_reg == 32'h0000_0000)) else $error("flags do not match result");
endmodule
bind bxl_exec bxl_exec_props bxl_exec_props_inst (.*);

// ===== bxl_mem_model.sv
/* Memory stand-in for bxl_exec: answers each read after a chosen wait.
   Assumes requests are held until the acknowledge pulse. */
`timescale 1ns/10ps
module bxl_mem_model
(
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire        mem_req_reg,
   input  wire [31:0] mem_addr_reg,
   input  wire [1:0]  wait_cyc,
   output reg         mem_ack,
   output reg  [31:0] mem_rdata,
   output wire        mem_idle
);
   reg [1:0] cnt_reg;
   // Idle only while no read is outstanding
   assign mem_idle = !mem_req_reg && !mem_ack;
   // Data off the ack is inverted each cycle so stale words never match
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mem_ack   <= 1'b0;
         mem_rdata <= 32'h0000_0000;
         cnt_reg   <= 2'h0;
      end
      else if (mem_req_reg && !mem_ack && cnt_reg == wait_cyc)
      begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem_addr_reg ^ 32'hA5A5_0000;
         cnt_reg   <= 2'h0;
      end
      else
      begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt_reg   <= (mem_req_reg && !mem_ack) ? cnt_reg + 2'h1 : 2'h0;
      end
   end
endmodule

// ===== tb_top.sv
/* Self-checking bench for bxl_exec with the memory model.
   Assumes a combinational register file, modelled here. */
`timescale 1ns/10ps
module tb_top;
   typedef struct {logic [15:0] ins; logic [31:0] pc; logic [3:0] idx; logic [31:0] addr;
      logic [31:0] data;} bxl_row_t;
   reg        sys_clk, reset_n, instr_valid, instr_is_32, cond_pass, in_it_block, maint_idle;
   reg        flag_c_in;
   reg [31:0] instr, instr_pc;
   reg [1:0]  wait_cyc;
   wire        mem_ack, mem_idle, instr_ready_reg, done_reg, undef_reg, wb_en_reg, flag_wr_reg;
   wire        flag_n_reg, flag_z_reg, flag_c_reg, mem_req_reg, mem_aligned_reg, order_fence_reg;
   wire        full_scope_reg, flush_reg, bp_ctx_sync_reg;
   wire [3:0]  rd_a_idx_reg, rd_b_idx_reg, wb_idx_reg;
   wire [31:0] rd_a_data, rd_b_data, mem_rdata, wb_data_reg, mem_addr_reg, refetch_addr_reg;
   logic [31:0] addr_q[$], wdat_q[$];
   logic [3:0]  widx_q[$];
   logic        fl_seen, fence_seen, flush_seen, undef_seen, scope_seen, al_seen;
   logic [31:0] rf_addr;
   bxl_row_t    rows[6];
   int          fails, checks, ncyc, stall_n, i, k, o;
   // Register k reads k in the top nibble, bit 31 flipped for odd k so N can rise
   function automatic logic [31:0] rv(input logic [3:0] r);
      rv = {r[3] ^ r[0], r[2:0], 28'h000_1000};
   endfunction
   assign rd_a_data = rv(rd_a_idx_reg);
   assign rd_b_data = rv(rd_b_idx_reg);
   bxl_exec bxl_exec_inst (.*);
   bxl_mem_model bxl_mem_model_inst (.*);
   always #50 sys_clk = ~sys_clk;
   task chk(input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // One instruction, offered at a falling edge, watched until retirement
   task run(input logic [31:0] ins, input logic is32, input logic [31:0] pc, input logic cp,
      input logic it);
      addr_q.delete(); widx_q.delete(); wdat_q.delete(); ncyc = 0;
      {fl_seen, fence_seen, flush_seen, undef_seen, scope_seen, al_seen} = 6'h00;
      for (int w = 0; w < 50 && instr_ready_reg !== 1'b1; w++) @(negedge sys_clk);
      {instr, instr_is_32, instr_pc, cond_pass, in_it_block} = {ins, is32, pc, cp, it};
      maint_idle = (stall_n == 0);
      instr_valid = 1'b1;
      @(negedge sys_clk);
      instr_valid = 1'b0;
      repeat (60)
      begin
         if (mem_req_reg && mem_ack) addr_q.push_back(mem_addr_reg);
         if (wb_en_reg) begin widx_q.push_back(wb_idx_reg); wdat_q.push_back(wb_data_reg); end
         fl_seen |= flag_wr_reg; fence_seen |= order_fence_reg; undef_seen |= undef_reg;
         scope_seen |= full_scope_reg;
         al_seen |= mem_req_reg & mem_aligned_reg;
         if (flush_reg) begin flush_seen = 1'b1; rf_addr = refetch_addr_reg; end
         if (done_reg === 1'b1) break;
         @(negedge sys_clk);
         ncyc++;
         maint_idle = (ncyc >= stall_n);
      end
      chk(done_reg, 1'b1);
   endtask
   initial begin #(5000 * 100); fails++; stop_test(); end
   initial
   begin
      {sys_clk, reset_n, instr_valid, instr_is_32, cond_pass, in_it_block} = 6'h00;
      {instr, instr_pc, wait_cyc, stall_n, maint_idle, flag_c_in} = {64'h0, 2'h0, 32'h0, 2'h2};
      repeat (4) @(negedge sys_clk);
      chk(instr_ready_reg, 1'b0);
      reset_n = 1'b1;
      rows = '{'{16'h4051, 0, 4'h1, 0, 32'hB000_0000}, '{16'h405B, 0, 4'h3, 0, 0},
         '{16'h6FEA, 0, 4'h2, 32'hD000_107C, 0}, '{16'h6837, 0, 4'h7, 32'h6000_1000, 0},
         '{16'h9CFF, 0, 4'h4, 32'h5000_13FC, 0}, '{16'h4801, 32'h2006, 4'h0, 32'h2008, 0}};
      // Table: exclusive-OR and the three word-load addressing forms
      foreach (rows[i])
      begin
         run({16'h0000, rows[i].ins}, 1'b0, rows[i].pc, 1'b1, 1'b0);
         chk(addr_q.size(), rows[i].addr != 0);
         if (addr_q.size() > 0) chk(addr_q[0], rows[i].addr);
         chk(widx_q.size(), 1);
         if (widx_q.size() > 0) chk({widx_q[0], wdat_q[0]}, {rows[i].idx, rows[i].addr != 0 ?
            rows[i].addr ^ 32'hA5A5_0000 : rows[i].data});
         chk(fl_seen, rows[i].addr == 0);
         chk(al_seen, 1'b0);
         if (rows[i].addr == 0)
            chk({flag_n_reg, flag_z_reg}, {rows[i].data[31], rows[i].data == 0});
      end
      chk(flag_c_reg, 1'b0);
      flag_c_in = 1'b1;
      run(32'h0000_4049, 1'b0, 0, 1'b1, 1'b1);
      chk({fl_seen, flag_c_reg}, 2'b00);
      run(32'h0000_4049, 1'b0, 0, 1'b0, 1'b0);
      chk(widx_q.size(), 0);
      run(32'h0000_0000, 1'b0, 0, 1'b1, 1'b0);
      chk(undef_seen, 1'b1);
      // Load list with a slow memory: base outside, then inside the list
      wait_cyc = 2'h2;
      run(32'h0000_C905, 1'b0, 0, 1'b1, 1'b0);
      chk(addr_q.size(), 2);
      chk(al_seen, 1'b1);
      if (addr_q.size() == 2) chk(addr_q[1] - addr_q[0], 32'h0000_0004);
      chk(widx_q.size(), 3);
      if (widx_q.size() == 3) chk({widx_q[0], widx_q[1], widx_q[2], wdat_q[2]},
         {12'h021, 32'h9000_1008});
      run(32'h0000_C90A, 1'b0, 0, 1'b1, 1'b0);
      chk(widx_q.size(), 2);
      wait_cyc = 2'h0;
      // Every barrier kind with every option, maintenance busy at the start
      stall_n = 3;
      for (k = 4; k < 7; k++)
         for (o = 0; o < 16; o++)
         begin
            i = k;
            run({16'hF3BF, 8'h8F, i[3:0], o[3:0]}, 1'b1, 32'h0000_3004, 1'b1, 1'b0);
            chk({scope_seen, undef_seen}, 2'h2);
            chk({fence_seen, flush_seen}, {i == 5, i == 6});
            if (i != 5) chk(ncyc > stall_n, 1'b1);
            if (i == 6) chk(rf_addr, 32'h0000_3004);
         end
      stall_n = 0;
      // Second reset between operations, then recovery
      reset_n = 1'b0;
      @(negedge sys_clk);
      chk({instr_ready_reg, mem_req_reg, wb_en_reg}, 3'h0);
      reset_n = 1'b1;
      run(32'h0000_405B, 1'b0, 0, 1'b1, 1'b0);
      chk(wdat_q.size() > 0 ? wdat_q[0] : 32'hFFFF_FFFF, 32'h0000_0000);
      chk(flag_c_reg, 1'b1);
      stop_test();
   end
endmodule
